/* hdl/gpi_edge_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module gpi_edge_sync (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	input  wire logic [3:0] gpi_in,
	gpi_if.det              port
);

	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] lvl;
	logic [3:0] next_lvl;
	logic [3:0] rise_q;
	logic [3:0] next_rise;
	logic [3:0] fall_q;
	logic [3:0] next_fall;

	// ==========================================================
	// edge detection on agreed levels
	// a level counts only once stages two and three agree
	always_comb begin
		next_lvl  = lvl;
		next_rise = 4'h0;
		next_fall = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (s2[i] == s3[i] && s3[i] != lvl[i]) begin // see [R14]
				next_lvl[i] = s3[i];
				next_rise[i] = s3[i] ~^ port.active_high[i];
				next_fall[i] = s3[i] ^ port.active_high[i];
			end
		end
	end

	// three-stage chain, first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s1     <= 4'h0;
			s2     <= 4'h0;
			s3     <= 4'h0;
			lvl    <= 4'h0;
			rise_q <= 4'h0;
			fall_q <= 4'h0;
		end else begin
			s1     <= gpi_in;
			s2     <= s1;
			s3     <= s2;
			lvl    <= next_lvl;
			rise_q <= next_rise;
			fall_q <= next_fall;
		end
	end

	// polarity applied after the level so a type change is no edge
	assign port.active = lvl ~^ port.active_high;
	assign port.rise   = rise_q;
	assign port.fall   = fall_q;

	// ==========================================================
	// checks
	AST_EDGE_NEEDS_AGREEMENT: assert property (@(posedge clk_in) disable iff (srst_in) // see [R14]
		|(rise_q | fall_q) |-> $past(s2) == $past(s3) && $past(lvl) != lvl)
		else $error("edge pulse without an agreed level change");

endmodule : gpi_edge_sync

`default_nettype wire

/* hdl/gpi_if.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// general inputs after synchronising, with edge pulses
interface gpi_if;
	logic [3:0] active_high;
	logic [3:0] active;
	logic [3:0] rise;
	logic [3:0] fall;

	modport det (input active_high, output active, rise, fall);
	modport use_side (output active_high, input active, rise, fall);
endinterface : gpi_if

`default_nettype wire

/* hdl/supply_ctl_pkg.sv */
package supply_ctl_pkg;

	// ==========================================================
	// register offsets on the 2-wire register port
	localparam logic [7:0] OFS_OUT_FN     = 8'h1f;
	localparam logic [7:0] OFS_BUCK_ONE   = 8'h21;
	localparam logic [7:0] OFS_BUCK_THREE = 8'h22;
	localparam logic [7:0] OFS_BUCK_TWO   = 8'h24;
	localparam logic [7:0] OFS_LINREG_ONE = 8'h26;

	// ==========================================================
	// writable bits, reset value, unmapped read answer
	localparam logic [7:0] MASK_OUT_FN  = 8'h1f;
	localparam logic [7:0] MASK_BUCK    = 8'h6f;
	localparam logic [7:0] MASK_LINREG  = 8'hef;
	localparam logic [7:0] RESET_VAL    = 8'h00;
	localparam logic [7:0] RD_UNMAPPED  = 8'h00;

	// ==========================================================
	// field positions
	localparam int BIT_ON          = 0;
	localparam int BIT_EN_SRC_LO   = 1;
	localparam int BIT_BUCK_CONF   = 3;
	localparam int BIT_PD_OFF      = 3;
	localparam int BIT_V_SRC_LO    = 5;
	localparam int BIT_LINREG_CONF = 7;
	localparam int BIT_P3_FN_LO    = 0;
	localparam int BIT_P4_FN_LO    = 3;

	// ==========================================================
	// supply slots, pin slots, counts
	localparam int NUM_SUPPLY = 4;
	localparam int NUM_GPI    = 4;
	localparam int NUM_PIN    = 2;
	localparam logic [1:0] IDX_BUCK_ONE   = 2'h0;
	localparam logic [1:0] IDX_BUCK_THREE = 2'h1;
	localparam logic [1:0] IDX_BUCK_TWO   = 2'h2;
	localparam logic [1:0] IDX_LINREG     = 2'h3;
	localparam int PIN3 = 0;
	localparam int PIN4 = 1;

	// ==========================================================
	// field encodings
	typedef enum logic [1:0] {
		SRC_SEQ  = 2'h0,
		SRC_GENERAL_INPUT_1 = 2'h1,
		SRC_GENERAL_INPUT_2 = 2'h2,
		SRC_GENERAL_INPUT_3 = 2'h3
	} src_t;

	typedef enum logic [1:0] {
		P4_STATIC = 2'h0,
		P4_FAULT  = 2'h1,
		P4_SEQ    = 2'h3
	} pin4_fn_t;

	typedef enum logic [2:0] {
		P3_STATIC = 3'h0,
		P3_FAULT  = 3'h1,
		P3_SEQ    = 3'h3,
		P3_FWD0   = 3'h4,
		P3_FWD1   = 3'h5,
		P3_FWD2   = 3'h6
	} pin3_fn_t;

endpackage : supply_ctl_pkg

/* hdl/supply_gpi_control_regs.sv */
// Summary of operation
// [R1] Pin 4 function bits 4:3 give static level, fault signal, sequencer drive or reserved 10.
// [R2] Pin 3 function bits 2:0 give static, fault, sequencer, or forward input 0, 1 or 2.
// [R3] Buck 1 bits 6:5 pick the sequencer or input 1-3; its edges pick voltage set A or B.
// [R4] Bits 2:1 of every supply pick the sequencer or input 1-3; its edges enable or disable.
// [R5] A buck's bit 0 enables it, applied only when the on/off ordering grants it.
// [R6] A buck's bit 3 marks it default or sequenced and kept on in power-down.
// [R7] Buck 3 has buck 1's layout with voltage source in bits 6:5 and bits 7, 4 reserved.
// [R8] Buck 2 has buck 1's layout with voltage source in bits 6:5.
// [R9] LDO 1 bit 7 is its default-or-sequenced bit and bits 6:5 its voltage source.
// [R10] LDO 1 bit 3 set keeps the pull-down off while disabled, else disabled means pulled down.
// [R11] LDO 1 bit 0 enables it, subject to the on/off ordering.
// [R12] A pin's mode bit is its level when static and its polarity, 1 active high, otherwise.
// [R13] Each supply holds a select bit, 0 for set A and 1 for set B, updated by input edges.
// [R14] Inputs are synchronised before edge detection; reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module supply_gpi_control_regs (
	input  wire logic                                  CLK_IN,
	input  wire logic                                  SRST_IN,
	input  wire logic [7:0]                            REG_ADDR_IN,
	input  wire logic [7:0]                            REG_WDATA_IN,
	input  wire logic                                  REG_WR_IN,
	input  wire logic                                  REG_RD_IN,
	input  wire logic [supply_ctl_pkg::NUM_GPI-1:0]    GPI_IN,
	input  wire logic [supply_ctl_pkg::NUM_GPI-1:0]    GPI_ACTIVE_HIGH_IN,
	input  wire logic [supply_ctl_pkg::NUM_PIN-1:0]    PIN_LEVEL_POLARITY_IN,
	input  wire logic [supply_ctl_pkg::NUM_PIN-1:0]    SEQ_PIN_IN,
	input  wire logic [supply_ctl_pkg::NUM_SUPPLY-1:0] SEQ_VSEL_IN,
	input  wire logic [supply_ctl_pkg::NUM_SUPPLY-1:0] ORDER_GRANT_IN,
	input  wire logic                                  SUPPLY_FAULT_N_IN,
	output var  logic [7:0]                            REG_RDATA_OUT,
	output var  logic                                  REG_RVALID_OUT,
	output var  logic [supply_ctl_pkg::NUM_SUPPLY-1:0] SUPPLY_ON_OUT,
	output var  logic [supply_ctl_pkg::NUM_SUPPLY-1:0] VOLT_SET_B_OUT,
	output var  logic [supply_ctl_pkg::NUM_SUPPLY-1:0] DEFAULT_OR_SEQ_OUT,
	output var  logic                                  LINREG_PULLDOWN_OUT,
	output var  logic                                  PIN3_OUT,
	output var  logic                                  PIN4_OUT
);
	import supply_ctl_pkg::*;

	logic [7:0]            out_fn;
	logic [7:0]            next_out_fn;
	logic [7:0]            ctl [NUM_SUPPLY];
	logic [7:0]            next_ctl [NUM_SUPPLY];
	logic [NUM_SUPPLY-1:0] next_on;
	logic [NUM_SUPPLY-1:0] next_vsel;
	logic                  next_pd;
	logic                  next_pin3;
	logic                  next_pin4;
	logic [7:0]            next_rdata;
	logic                  next_rvalid;
	logic [2:0]            wdec;
	logic [2:0]            rdec;

	gpi_if gif ();

	assign gif.active_high = GPI_ACTIVE_HIGH_IN;

	gpi_edge_sync u_sync (
		.clk_in  (CLK_IN),
		.srst_in (SRST_IN),
		.gpi_in  (GPI_IN),
		.port    (gif.det)
	);

	// ==========================================================
	// helpers
	// address to {hit, slot}; used by both write and read paths
	function automatic logic [2:0] decode_addr(input logic [7:0] a);
		unique case (a)
			OFS_BUCK_ONE:   return {1'b1, IDX_BUCK_ONE};
			OFS_BUCK_THREE: return {1'b1, IDX_BUCK_THREE};
			OFS_BUCK_TWO:   return {1'b1, IDX_BUCK_TWO};
			OFS_LINREG_ONE: return {1'b1, IDX_LINREG};
			default:        return {1'b0, IDX_BUCK_ONE};
		endcase
	endfunction : decode_addr

	// edge of the input that a source field names; sequencer source sees none
	function automatic logic pick(input logic [1:0] src, input logic [3:0] v);
		return (src == SRC_SEQ) ? 1'b0 : v[src];
	endfunction : pick

	// polarity from the mode bit: 1 drives the active state high
	function automatic logic polar(input logic pol, input logic act);
		return pol ? act : ~act;
	endfunction : polar

	function automatic logic [7:0] wmask(input logic [1:0] idx);
		return (idx == IDX_LINREG) ? MASK_LINREG : MASK_BUCK;
	endfunction : wmask

	// ==========================================================
	// register file, supply state and pin functions
	always_comb begin
		next_out_fn = out_fn;
		next_ctl    = ctl;
		next_on     = SUPPLY_ON_OUT;
		next_vsel   = VOLT_SET_B_OUT;
		next_rdata  = REG_RDATA_OUT;
		next_rvalid = 1'b0;
		wdec        = decode_addr(REG_ADDR_IN);
		rdec        = decode_addr(REG_ADDR_IN);
		// host writes, reserved bits masked away
		if (REG_WR_IN) begin
			if (REG_ADDR_IN == OFS_OUT_FN) begin
				next_out_fn = REG_WDATA_IN & MASK_OUT_FN; // see [R14]
			end else if (wdec[2]) begin
				next_ctl[wdec[1:0]] = REG_WDATA_IN & wmask(wdec[1:0]); // see [R7]
			end
		end
		for (int i = 0; i < NUM_SUPPLY; i++) begin
			// input edge beats a host write of the same cycle
			if (pick(ctl[i][BIT_EN_SRC_LO +: 2], gif.rise)) begin
				next_ctl[i][BIT_ON] = 1'b1; // see [R4]
			end else if (pick(ctl[i][BIT_EN_SRC_LO +: 2], gif.fall)) begin
				next_ctl[i][BIT_ON] = 1'b0; // see [R4]
			end
			// voltage set select: sequencer copy or input edges
			if (ctl[i][BIT_V_SRC_LO +: 2] == SRC_SEQ) begin
				next_vsel[i] = SEQ_VSEL_IN[i];
			end else if (pick(ctl[i][BIT_V_SRC_LO +: 2], gif.rise)) begin
				next_vsel[i] = 1'b0; // see [R3] see [R8] see [R9] see [R13]
			end else if (pick(ctl[i][BIT_V_SRC_LO +: 2], gif.fall)) begin
				next_vsel[i] = 1'b1; // see [R3] see [R13]
			end
			// enable reaches the supply only in its ordering slot
			if (ORDER_GRANT_IN[i]) begin
				next_on[i] = ctl[i][BIT_ON]; // see [R5] see [R11]
			end
		end
		// pull-down follows the actual supply state, not the request
		next_pd = ~SUPPLY_ON_OUT[IDX_LINREG] & ~ctl[IDX_LINREG][BIT_PD_OFF]; // see [R10]
		unique case (out_fn[BIT_P4_FN_LO +: 2])
			P4_STATIC: next_pin4 = PIN_LEVEL_POLARITY_IN[PIN4]; // see [R1] see [R12]
			P4_FAULT:  next_pin4 = polar(PIN_LEVEL_POLARITY_IN[PIN4], ~SUPPLY_FAULT_N_IN);
			P4_SEQ:    next_pin4 = polar(PIN_LEVEL_POLARITY_IN[PIN4], SEQ_PIN_IN[PIN4]);
			default:   next_pin4 = 1'b0; // reserved code holds the pin low
		endcase
		unique case (out_fn[BIT_P3_FN_LO +: 3])
			P3_STATIC: next_pin3 = PIN_LEVEL_POLARITY_IN[PIN3]; // see [R2] see [R12]
			P3_FAULT:  next_pin3 = polar(PIN_LEVEL_POLARITY_IN[PIN3], ~SUPPLY_FAULT_N_IN);
			P3_SEQ:    next_pin3 = polar(PIN_LEVEL_POLARITY_IN[PIN3], SEQ_PIN_IN[PIN3]);
			P3_FWD0, P3_FWD1, P3_FWD2: begin
				next_pin3 = polar(PIN_LEVEL_POLARITY_IN[PIN3],
					gif.active[out_fn[BIT_P3_FN_LO +: 2]]); // see [R2]
			end
			default:   next_pin3 = 1'b0;
		endcase
		// reads return the value before any write of the same cycle
		if (REG_RD_IN) begin
			next_rvalid = 1'b1;
			if (REG_ADDR_IN == OFS_OUT_FN) begin
				next_rdata = out_fn;
			end else if (rdec[2]) begin
				next_rdata = ctl[rdec[1:0]]; // see [R14]
			end else begin
				next_rdata = RD_UNMAPPED;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			out_fn              <= RESET_VAL;
			for (int i = 0; i < NUM_SUPPLY; i++) begin
				ctl[i] <= RESET_VAL;
			end
			SUPPLY_ON_OUT       <= '0;
			VOLT_SET_B_OUT      <= '0;
			LINREG_PULLDOWN_OUT <= 1'b1;
			PIN3_OUT            <= 1'b0;
			PIN4_OUT            <= 1'b0;
			REG_RDATA_OUT       <= RESET_VAL;
			REG_RVALID_OUT      <= 1'b0;
		end else begin
			out_fn              <= next_out_fn;
			ctl                 <= next_ctl;
			SUPPLY_ON_OUT       <= next_on;
			VOLT_SET_B_OUT      <= next_vsel;
			LINREG_PULLDOWN_OUT <= next_pd;
			PIN3_OUT            <= next_pin3;
			PIN4_OUT            <= next_pin4;
			REG_RDATA_OUT       <= next_rdata;
			REG_RVALID_OUT      <= next_rvalid;
		end
	end

	// ==========================================================
	// configuration bits: bucks hold it in bit 3, the LDO in bit 7
	generate
		for (genvar g = 0; g < NUM_SUPPLY; g++) begin : g_conf
			if (g == IDX_LINREG) begin : g_lin
				assign DEFAULT_OR_SEQ_OUT[g] = ctl[g][BIT_LINREG_CONF]; // see [R9]
			end else begin : g_buck
				assign DEFAULT_OR_SEQ_OUT[g] = ctl[g][BIT_BUCK_CONF]; // see [R6]
			end
		end
	endgenerate

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SRST_IN);

	AST_P4_STATIC_LEVEL: assert property ( // see [R1]
		out_fn[BIT_P4_FN_LO +: 2] == P4_STATIC |=> PIN4_OUT == $past(PIN_LEVEL_POLARITY_IN[PIN4]))
		else $error("pin 4 static level wrong");
	AST_P4_FAULT_POLARITY: assert property ( // see [R12]
		out_fn[BIT_P4_FN_LO +: 2] == P4_FAULT
		|=> PIN4_OUT == ($past(PIN_LEVEL_POLARITY_IN[PIN4]) ^ $past(SUPPLY_FAULT_N_IN)))
		else $error("pin 4 fault output polarity wrong");
	AST_P3_FORWARD_ONE: assert property ( // see [R2]
		out_fn[BIT_P3_FN_LO +: 3] == P3_FWD1
		|=> PIN3_OUT == ($past(PIN_LEVEL_POLARITY_IN[PIN3]) ~^ $past(gif.active[1])))
		else $error("pin 3 does not forward input 1");
	AST_P3_RESERVED_LOW: assert property ( // see [R2]
		out_fn[BIT_P3_FN_LO +: 3] inside {3'h2, 3'h7} |=> !PIN3_OUT)
		else $error("pin 3 reserved code not low");
	AST_GPI_ENABLES: assert property ( // see [R4]
		pick(ctl[IDX_BUCK_TWO][BIT_EN_SRC_LO +: 2], gif.rise) |=> ctl[IDX_BUCK_TWO][BIT_ON])
		else $error("input rise did not enable buck 2");
	AST_GPI_DISABLES: assert property ( // see [R4]
		pick(ctl[IDX_BUCK_TWO][BIT_EN_SRC_LO +: 2], gif.fall) |=> !ctl[IDX_BUCK_TWO][BIT_ON])
		else $error("input fall did not disable buck 2");
	AST_VSET_A_ON_RISE: assert property ( // see [R13]
		pick(ctl[IDX_BUCK_THREE][BIT_V_SRC_LO +: 2], gif.rise)
		|=> !VOLT_SET_B_OUT[IDX_BUCK_THREE])
		else $error("rise did not pick voltage set A");
	AST_ORDER_HOLDS: assert property ( // see [R5]
		!ORDER_GRANT_IN[IDX_BUCK_THREE] |=> $stable(SUPPLY_ON_OUT[IDX_BUCK_THREE]))
		else $error("buck 3 changed without an ordering grant");
	AST_GRANT_APPLIES: assert property ( // see [R11]
		ORDER_GRANT_IN[IDX_LINREG] ##1 ORDER_GRANT_IN[IDX_LINREG]
		|-> SUPPLY_ON_OUT[IDX_LINREG] == $past(ctl[IDX_LINREG][BIT_ON]))
		else $error("granted LDO enable not applied");
	AST_PULLDOWN_WHEN_OFF: assert property ( // see [R10]
		!SUPPLY_ON_OUT[IDX_LINREG] && !ctl[IDX_LINREG][BIT_PD_OFF]
		##1 !SUPPLY_ON_OUT[IDX_LINREG] |-> LINREG_PULLDOWN_OUT)
		else $error("disabled LDO not pulled down");
	AST_RESERVED_READ_ZERO: assert property ( // see [R14]
		REG_RD_IN && REG_ADDR_IN == OFS_BUCK_THREE |=> REG_RVALID_OUT && !REG_RDATA_OUT[7]
		&& !REG_RDATA_OUT[4])
		else $error("reserved bits of buck 3 read non-zero");

	COV_GPI_ENABLE: cover property (pick(ctl[IDX_BUCK_TWO][BIT_EN_SRC_LO +: 2], gif.rise));
	COV_P3_FORWARD: cover property (out_fn[BIT_P3_FN_LO +: 3] == P3_FWD2 ##1 PIN3_OUT);
	COV_ORDER_WAIT: cover property (!ORDER_GRANT_IN[IDX_LINREG] && ctl[IDX_LINREG][BIT_ON]
		##1 ORDER_GRANT_IN[IDX_LINREG]);

endmodule : supply_gpi_control_regs

`default_nettype wire

/* test/host_port_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// host side of the register port
module host_port_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output var  logic [7:0] addr_out,
	output var  logic [7:0] wdata_out,
	output var  logic       wr_out,
	output var  logic       rd_out
);
	// idle lines carry the inverse of the last value, never a stale copy
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// one-cycle strobe; the leading wait keeps two requests a cycle apart
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask : wr

	// answer awaited a few cycles only, so a lost answer reads as unknown
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		d = 8'hxx;
		for (int i = 0; i < 4; i++) begin
			if (rvalid_in === 1'b1) begin
				d = rdata_in;
				break;
			end
			@(negedge clk_in);
		end
	endtask : rd
endmodule : host_port_model

`default_nettype wire

/* test/supply_gpi_control_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none

module supply_gpi_control_regs_test;
	import supply_ctl_pkg::*;

	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} reg_row_t;
	typedef struct packed {
		logic [7:0] fn;
		logic [1:0] pol;
		logic       flt_n;
		logic [1:0] seqp;
		logic [3:0] gpi;
		logic [1:0] pins;
	} pin_row_t;

	// ==========================================================
	// register map: write all ones, expect only the writable bits back
	localparam reg_row_t REG_ROWS [7] = '{
		'{8'h1f, 8'hff, 8'h1f}, '{8'h21, 8'hff, 8'h6f}, '{8'h22, 8'hff, 8'h6f},
		'{8'h24, 8'hff, 8'h6f}, '{8'h26, 8'hff, 8'hef}, '{8'h20, 8'hff, 8'h00},
		'{8'h23, 8'hff, 8'h00}};
	// pin functions: {pin4, pin3} expected; input 1 is active low
	localparam pin_row_t PIN_ROWS [11] = '{
		'{8'h00, 2'b11, 1'b1, 2'b00, 4'b0010, 2'b11},
		'{8'h00, 2'b00, 1'b1, 2'b00, 4'b0010, 2'b00},
		'{8'h09, 2'b11, 1'b0, 2'b00, 4'b0010, 2'b11},
		'{8'h09, 2'b11, 1'b1, 2'b00, 4'b0010, 2'b00},
		'{8'h09, 2'b00, 1'b0, 2'b00, 4'b0010, 2'b00},
		'{8'h1b, 2'b11, 1'b1, 2'b01, 4'b0010, 2'b01},
		'{8'h14, 2'b11, 1'b1, 2'b00, 4'b0011, 2'b01},
		'{8'h05, 2'b01, 1'b1, 2'b00, 4'b0000, 2'b01},
		'{8'h06, 2'b11, 1'b1, 2'b00, 4'b0110, 2'b11},
		'{8'h02, 2'b11, 1'b1, 2'b00, 4'b0110, 2'b10},
		'{8'h07, 2'b11, 1'b1, 2'b00, 4'b0010, 2'b10}};

	logic       clk, srst, wr, rd, flt_n, rvalid, pd, p3, p4;
	logic [7:0] addr, wdata, rdata, got;
	logic [3:0] gpi, gpi_ah, vsel, grant, on, vb, dos;
	logic [1:0] pol, seqp;
	int         n_mismatch, cmp_count;

	always #4 clk = ~clk;

	supply_gpi_control_regs i_dut (
		.CLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .GPI_IN(gpi), .GPI_ACTIVE_HIGH_IN(gpi_ah),
		.PIN_LEVEL_POLARITY_IN(pol), .SEQ_PIN_IN(seqp), .SEQ_VSEL_IN(vsel),
		.ORDER_GRANT_IN(grant), .SUPPLY_FAULT_N_IN(flt_n), .REG_RDATA_OUT(rdata),
		.REG_RVALID_OUT(rvalid), .SUPPLY_ON_OUT(on), .VOLT_SET_B_OUT(vb),
		.DEFAULT_OR_SEQ_OUT(dos), .LINREG_PULLDOWN_OUT(pd), .PIN3_OUT(p3), .PIN4_OUT(p4));

	host_port_model i_host (
		.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));

	// ==========================================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			n_mismatch++;
		end
	endtask : chk

	task automatic conclude();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		gpi = 4'b0010;
		gpi_ah = 4'b1101;
		pol = 2'b00;
		seqp = 2'b00;
		vsel = 4'h0;
		grant = 4'b1101;
		flt_n = 1'b1;
		n_mismatch = 0;
		cmp_count = 0;
		tick(10);
		srst = 1'b0;
		chk("outputs after reset", 8'h10, {3'h0, pd, on});
		foreach (REG_ROWS[i]) begin
			i_host.rd(REG_ROWS[i].a, got);
			chk("reset value", 8'h00, got);
			i_host.wr(REG_ROWS[i].a, REG_ROWS[i].w);
			i_host.rd(REG_ROWS[i].a, got);
			chk("read back", REG_ROWS[i].e, got);
			i_host.wr(REG_ROWS[i].a, 8'h00);
		end
		foreach (PIN_ROWS[i]) begin
			pol = PIN_ROWS[i].pol;
			flt_n = PIN_ROWS[i].flt_n;
			seqp = PIN_ROWS[i].seqp;
			gpi = PIN_ROWS[i].gpi;
			i_host.wr(OFS_OUT_FN, PIN_ROWS[i].fn);
			tick(8);
			chk("pin levels", {6'h00, PIN_ROWS[i].pins}, {6'h00, p4, p3});
		end
		// buck three is held back until the ordering grants it
		i_host.wr(OFS_BUCK_ONE, 8'h09);
		i_host.wr(OFS_BUCK_THREE, 8'h01);
		tick(3);
		chk("supply on", 8'h01, {4'h0, on});
		chk("default or seq", 8'h01, {4'h0, dos});
		grant = 4'b1111;
		tick(3);
		chk("supply on granted", 8'h03, {4'h0, on});
		// linear regulator pull-down follows the enable unless kept off
		i_host.wr(OFS_LINREG_ONE, 8'h80);
		tick(3);
		chk("pulldown while off", 8'h19, {3'h0, pd, dos});
		i_host.wr(OFS_LINREG_ONE, 8'h88);
		tick(3);
		chk("pulldown kept off", 8'h00, {7'h00, pd});
		i_host.wr(OFS_LINREG_ONE, 8'h81);
		tick(3);
		chk("linreg on", 8'h0b, {3'h0, pd, on});
		// enable by edges on input 2
		i_host.wr(OFS_BUCK_TWO, 8'h04);
		gpi[2] = 1'b1;
		tick(10);
		chk("input enable", 8'h0f, {4'h0, on});
		i_host.rd(OFS_BUCK_TWO, got);
		chk("enable bit by edge", 8'h05, got);
		gpi[2] = 1'b0;
		tick(10);
		chk("input disable", 8'h0b, {4'h0, on});
		// voltage sets: buck one on active-low input 1, buck three and linreg on 3
		i_host.wr(OFS_BUCK_ONE, 8'h29);
		i_host.wr(OFS_BUCK_THREE, 8'h61);
		i_host.wr(OFS_LINREG_ONE, 8'he1);
		vsel = 4'b0100;
		gpi[1] = 1'b0;
		gpi[3] = 1'b1;
		tick(10);
		chk("volt set a", 8'h04, {4'h0, vb});
		gpi[1] = 1'b1;
		gpi[3] = 1'b0;
		tick(10);
		chk("volt set b", 8'h0f, {4'h0, vb});
		gpi[3] = 1'b1;
		tick(10);
		chk("volt set a again", 8'h05, {4'h0, vb});
		// reset in mid-run returns everything to its reset value again, pull-down on
		srst = 1'b1;
		tick(2);
		srst = 1'b0;
		chk("outputs after second reset", 8'h10, {3'h0, pd, on});
		chk("volt set after second reset", 8'h00, {4'h0, vb});
		i_host.rd(OFS_BUCK_ONE, got);
		chk("register after second reset", 8'h00, got);
		conclude();
	end
endmodule : supply_gpi_control_regs_test

`default_nettype wire
